// *** verilog/fce_consts.vh ***
// Purpose: constants of the flash command executor
// Assumes: 32-bit Avalon-MM slave, one word per register
// Notes:   tick counts are in flash timebase periods
// Contract
// - 0x05 verifies whole block, sets blank flag only if every word reads erased
// - 0x06 compresses; signature lands in data register
// - 0x20 programs one 16-bit word timed
// - 0x40 erases the sector of buffered address
// - 0x41 mass erase only with all protect bits
// - 0x47 aborts an active sector erase cleanly
// - verify takes address count plus 12 cycles
// - completion flag sets unless command is buffered
// - compress counts data words; zero means 64K
// - compress takes twice words plus 20 cycles
// - compress address wraps at end of block
// - buffer-empty stays clear during compress
// - new sequence during compress sets access error
// - protected target sets violation, no launch
// - abort sets access error only if cut short
// - abort that cuts an erase short ends within one timebase plus four
// - buffer-empty clear during abort; new sequence errors
// - launch clears completion; buffer-empty four cycles later
`ifndef FCE_CONSTS_VH
`define FCE_CONSTS_VH
`define FCE_OFF_CMD      8'h00
`define FCE_OFF_STAT     8'h04
`define FCE_OFF_PROT     8'h08
`define FCE_OFF_DATA     8'h0C
`define FCE_OFF_DIV      8'h10
`define FCE_ARR_BIT      19
`define FCE_CMD_VERIFY   8'h05
`define FCE_CMD_COMPRESS 8'h06
`define FCE_CMD_PROG     8'h20
`define FCE_CMD_SERASE   8'h40
`define FCE_CMD_MERASE   8'h41
`define FCE_CMD_ABORT    8'h47
`define FCE_ST_CBE       7
`define FCE_ST_CCI       6
`define FCE_ST_PROTECTION_VIOLATION_FLAG     5
`define FCE_ST_ACCESS_ERROR_FLAG    4
`define FCE_ST_BLANK     2
`define FCE_PROT_OPEN    7
`define FCE_PROT_HI      5
`define FCE_PROT_LO      2
`define FCE_PROT_RST     8'hA4
`define FCE_DIV_RST      8'h00
`define FCE_PROG_TICKS   20'h00008
`define FCE_SERASE_TICKS 20'h00040
`define FCE_MERASE_TICKS 20'h00080
`define FCE_LAUNCH_DLY   2'h3
`define FCE_VFY_TAIL     20'h00007
`define FCE_CMP_TAIL     20'h0000F
`define FCE_ABT_TAIL     20'h00003
`define FCE_SIG_SEED     16'hFFFF
`define FCE_ERASED       16'hFFFF
`endif

// *** verilog/fce_flash_cmd_exec.v ***
// Purpose: command executor of an on-chip flash block with its array
// Assumes: one clock sys_clk at 40 MHz; Avalon-MM slave with one wait state
// Notes:   flash timebase is an enable pulse from a programmable divider
`timescale 1ns/1ps
`include "fce_consts.vh"
module fce_flash_cmd_exec #(
	parameter ADDR_W = 16,
	parameter SECT_W = 9
) (
	input  wire        sys_clk,
	input  wire        arst_n,
	input  wire [19:0] avs_address,
	input  wire        avs_read,
	input  wire        avs_write,
	input  wire [3:0]  avs_byteenable,
	input  wire [31:0] avs_writedata,
	output reg  [31:0] avs_readdata,
	output reg         avs_waitrequest
);
////////////////////////////////////////////////////////////////////////////////
localparam ST_IDLE = 3'h0;
localparam ST_VFY  = 3'h1;
localparam ST_CMP  = 3'h2;
localparam ST_TIME = 3'h3;
localparam ST_SWP  = 3'h4;
localparam ST_TAIL = 3'h5;
reg [15:0]       mem [0:(1<<ADDR_W)-1];
reg [7:0]        cmd_reg;
reg [ADDR_W-1:0] addr_buf_reg;
reg [15:0]       data_buf_reg;
reg              buf_valid_reg;
reg              hold_reg;
reg [1:0]        seq_reg;
reg              command_complete_flag_reg;
reg              access_error_flag_reg;
reg              protection_violation_flag_reg;
reg              blank_reg;
reg [7:0]        prot_reg;
reg [7:0]        div_reg;
reg              div_ld_reg;
reg [7:0]        fcnt_reg;
reg              tick_reg;
reg [1:0]        ldly_reg;
reg [2:0]        state_reg;
reg [7:0]        op_reg;
reg [ADDR_W-1:0] a_addr_reg;
reg [15:0]       a_data_reg;
reg [19:0]       tcnt_reg;
reg [ADDR_W-1:0] idx_reg;
reg              half_reg;
reg              ok_reg;
reg [15:0]       word_reg;
reg [15:0]       sig_reg;
reg              abort_pend_reg;
reg              abort_hit_reg;
function prot_hit;
	input [ADDR_W-1:0] a;
	input [7:0]        p;
	begin
		prot_hit = !p[`FCE_PROT_OPEN]
			|| (!p[`FCE_PROT_HI] && a[ADDR_W-1:ADDR_W-2] == 2'h3)
			|| (!p[`FCE_PROT_LO] && a[ADDR_W-1:ADDR_W-2] == 2'h0);
	end
endfunction

////////////////////////////////////////////////////////////////////////////////
// bus decode: an access takes effect on the edge where waitrequest is low
wire              acc     = !avs_waitrequest && (avs_read || avs_write);
wire              wr      = acc && avs_write;
wire              is_arr  = avs_address[`FCE_ARR_BIT];
wire [7:0]        off     = avs_address[7:0];
wire              reg_hit = !is_arr && avs_address[18:8] == 11'h000 && avs_byteenable[0];
wire [ADDR_W-1:0] widx    = avs_address[ADDR_W+1:2];
wire              wr_arr  = wr && is_arr;
wire              wr_cmd  = wr && reg_hit && off == `FCE_OFF_CMD;
wire              wr_stat = wr && reg_hit && off == `FCE_OFF_STAT;
wire              wr_prot = wr && reg_hit && off == `FCE_OFF_PROT;
wire              wr_div  = wr && reg_hit && off == `FCE_OFF_DIV;
wire [7:0]        code    = avs_writedata[7:0];
wire              buffer_empty_flag   = !buf_valid_reg && !hold_reg;
wire code_ok = code == `FCE_CMD_VERIFY || code == `FCE_CMD_COMPRESS
	|| code == `FCE_CMD_PROG || code == `FCE_CMD_SERASE
	|| code == `FCE_CMD_MERASE || code == `FCE_CMD_ABORT;
// no new sequence while compress or abort owns the buffers
wire arr_err = wr_arr && (seq_reg != 2'h0 || hold_reg || !div_ld_reg || access_error_flag_reg || protection_violation_flag_reg
	|| avs_byteenable[1:0] != 2'h3 || (buf_valid_reg && cmd_reg == `FCE_CMD_COMPRESS));
wire cmd_err = wr_cmd && (seq_reg != 2'h1 || !code_ok);
wire cmd_pv  = wr_cmd && seq_reg == 2'h1 && code_ok && (
	((code == `FCE_CMD_PROG || code == `FCE_CMD_SERASE)
		&& prot_hit(addr_buf_reg, prot_reg))
	|| (code == `FCE_CMD_MERASE && !(prot_reg[`FCE_PROT_OPEN]
		&& prot_reg[`FCE_PROT_HI] && prot_reg[`FCE_PROT_LO])));
wire launch  = wr_stat && avs_writedata[`FCE_ST_CBE] && seq_reg == 2'h2;
wire cbe0    = wr_stat && !avs_writedata[`FCE_ST_CBE] && seq_reg != 2'h0;
wire oth_err = (wr_prot || wr_div) && seq_reg != 2'h0;
wire seq_err = arr_err || cmd_err || cbe0 || oth_err;
wire finish  = state_reg == ST_TAIL && tcnt_reg == 20'h00000;
wire start   = state_reg == ST_IDLE && buf_valid_reg && ldly_reg == 2'h0;
wire [15:0] fold = {sig_reg[14:0], sig_reg[15] ^ sig_reg[14] ^ sig_reg[12] ^ sig_reg[3]};

////////////////////////////////////////////////////////////////////////////////
// avalon slave: one wait state, read data registered with the answer
always @(posedge sys_clk or negedge arst_n) begin
	if (!arst_n) begin
		avs_waitrequest <= 1'b1;
		avs_readdata    <= 32'h00000000;
	end else begin
		avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
		if (avs_read && avs_waitrequest) begin
			avs_readdata <= 32'h00000000;
			if (is_arr)
				avs_readdata <= {16'h0000, mem[widx]};
			else if (avs_address[18:8] == 11'h000) begin
				case (off)
				`FCE_OFF_CMD:  avs_readdata <= {24'h000000, cmd_reg};
				`FCE_OFF_STAT: avs_readdata <= {24'h000000, buffer_empty_flag, command_complete_flag_reg, protection_violation_flag_reg,
					access_error_flag_reg, 1'b0, blank_reg, 2'h0};
				`FCE_OFF_PROT: avs_readdata <= {24'h000000, prot_reg};
				`FCE_OFF_DATA: avs_readdata <= {16'h0000, data_buf_reg};
				`FCE_OFF_DIV:  avs_readdata <= {23'h000000, div_ld_reg, div_reg};
				default:       avs_readdata <= 32'h00000000;
				endcase
			end
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// timebase divider: tick every div+1 bus cycles
always @(posedge sys_clk or negedge arst_n) begin
	if (!arst_n) begin
		fcnt_reg <= 8'h00;
		tick_reg <= 1'b0;
	end else if (fcnt_reg >= div_reg) begin
		fcnt_reg <= 8'h00;
		tick_reg <= 1'b1;
	end else begin
		fcnt_reg <= fcnt_reg + 8'h01;
		tick_reg <= 1'b0;
	end
end

////////////////////////////////////////////////////////////////////////////////
// command sequence, flags and execution engine
always @(posedge sys_clk or negedge arst_n) begin
	if (!arst_n) begin
		cmd_reg        <= 8'h00;
		addr_buf_reg   <= {ADDR_W{1'b0}};
		data_buf_reg   <= 16'h0000;
		buf_valid_reg  <= 1'b0;
		hold_reg       <= 1'b0;
		seq_reg        <= 2'h0;
		command_complete_flag_reg       <= 1'b1;
		access_error_flag_reg     <= 1'b0;
		protection_violation_flag_reg      <= 1'b0;
		blank_reg      <= 1'b0;
		prot_reg       <= `FCE_PROT_RST;
		div_reg        <= `FCE_DIV_RST;
		div_ld_reg     <= 1'b0;
		ldly_reg       <= 2'h0;
		state_reg      <= ST_IDLE;
		op_reg         <= 8'h00;
		a_addr_reg     <= {ADDR_W{1'b0}};
		a_data_reg     <= 16'h0000;
		tcnt_reg       <= 20'h00000;
		idx_reg        <= {ADDR_W{1'b0}};
		half_reg       <= 1'b0;
		ok_reg         <= 1'b0;
		word_reg       <= 16'h0000;
		sig_reg        <= `FCE_SIG_SEED;
		abort_pend_reg <= 1'b0;
		abort_hit_reg  <= 1'b0;
	end else begin
		if (wr_prot && !oth_err)
			prot_reg <= avs_writedata[7:0];
		if (wr_div && !oth_err) begin
			div_reg    <= avs_writedata[7:0];
			div_ld_reg <= 1'b1;
		end
		// flag clears first so that a same-cycle set wins
		if (wr_stat) begin
			if (avs_writedata[`FCE_ST_ACCESS_ERROR_FLAG])
				access_error_flag_reg <= 1'b0;
			if (avs_writedata[`FCE_ST_PROTECTION_VIOLATION_FLAG])
				protection_violation_flag_reg <= 1'b0;
			if (avs_writedata[`FCE_ST_BLANK])
				blank_reg <= 1'b0;
		end
		if (seq_err)
			access_error_flag_reg <= 1'b1;
		if (cmd_pv)
			protection_violation_flag_reg <= 1'b1;
		if (seq_err || cmd_pv)
			seq_reg <= 2'h0;
		else if (wr_arr) begin
			// restarting over a waiting command drops it
			seq_reg       <= 2'h1;
			addr_buf_reg  <= widx;
			data_buf_reg  <= avs_writedata[15:0];
			buf_valid_reg <= 1'b0;
		end else if (wr_cmd) begin
			seq_reg <= 2'h2;
			cmd_reg <= code;
		end else if (launch) begin
			seq_reg  <= 2'h0;
			command_complete_flag_reg <= 1'b0;
			if (cmd_reg == `FCE_CMD_ABORT) begin
				hold_reg <= 1'b1;
				if (state_reg == ST_IDLE) begin
					state_reg <= ST_TAIL;
					op_reg    <= `FCE_CMD_ABORT;
					tcnt_reg  <= `FCE_ABT_TAIL;
				end else
					abort_pend_reg <= 1'b1;
			end else begin
				buf_valid_reg <= 1'b1;
				ldly_reg      <= `FCE_LAUNCH_DLY;
			end
		end
		if (ldly_reg != 2'h0)
			ldly_reg <= ldly_reg - 2'h1;

		case (state_reg)
		ST_IDLE: begin
			if (start) begin
				buf_valid_reg <= 1'b0;
				op_reg        <= cmd_reg;
				a_addr_reg    <= addr_buf_reg;
				a_data_reg    <= data_buf_reg;
				idx_reg       <= {ADDR_W{1'b0}};
				case (cmd_reg)
				`FCE_CMD_VERIFY: begin
					state_reg <= ST_VFY;
					ok_reg    <= 1'b1;
					blank_reg <= 1'b0;
				end
				`FCE_CMD_COMPRESS: begin
					state_reg <= ST_CMP;
					hold_reg  <= 1'b1;
					half_reg  <= 1'b0;
					sig_reg   <= `FCE_SIG_SEED;
					tcnt_reg  <= (data_buf_reg == 16'h0000) ? 20'h10000
						: {4'h0, data_buf_reg};
				end
				`FCE_CMD_PROG: begin
					state_reg <= ST_TIME;
					tcnt_reg  <= `FCE_PROG_TICKS;
				end
				`FCE_CMD_SERASE: begin
					state_reg <= ST_TIME;
					tcnt_reg  <= `FCE_SERASE_TICKS;
				end
				default: begin
					state_reg <= ST_TIME;
					tcnt_reg  <= `FCE_MERASE_TICKS;
				end
				endcase
			end
		end
		ST_VFY: begin
			if (mem[idx_reg] != `FCE_ERASED)
				ok_reg <= 1'b0;
			idx_reg <= idx_reg + {{(ADDR_W-1){1'b0}}, 1'b1};
			if (idx_reg == {ADDR_W{1'b1}}) begin
				state_reg <= ST_TAIL;
				tcnt_reg  <= `FCE_VFY_TAIL;
			end
		end
		ST_CMP: begin
			// read then fold: two bus cycles per word
			half_reg <= !half_reg;
			if (!half_reg)
				word_reg <= mem[a_addr_reg];
			else begin
				sig_reg    <= fold ^ word_reg;
				a_addr_reg <= a_addr_reg + {{(ADDR_W-1){1'b0}}, 1'b1};
				tcnt_reg   <= tcnt_reg - 20'h00001;
				if (tcnt_reg == 20'h00001) begin
					state_reg <= ST_TAIL;
					tcnt_reg  <= `FCE_CMP_TAIL;
				end
			end
		end
		ST_TIME: begin
			if (tick_reg) begin
				if (abort_pend_reg && op_reg == `FCE_CMD_SERASE && tcnt_reg != 20'h00001) begin
					// cut short at the next timebase edge
					state_reg      <= ST_TAIL;
					tcnt_reg       <= `FCE_ABT_TAIL;
					abort_hit_reg  <= 1'b1;
					abort_pend_reg <= 1'b0;
				end else if (tcnt_reg == 20'h00001) begin
					if (op_reg == `FCE_CMD_PROG) begin
						// cells only clear bits, so reprogramming cannot set any
						mem[a_addr_reg] <= mem[a_addr_reg] & a_data_reg;
						state_reg       <= ST_TAIL;
						tcnt_reg        <= 20'h00000;
					end else
						state_reg <= ST_SWP;
				end else
					tcnt_reg <= tcnt_reg - 20'h00001;
			end
		end
		ST_SWP: begin
			idx_reg <= idx_reg + {{(ADDR_W-1){1'b0}}, 1'b1};
			if (op_reg == `FCE_CMD_SERASE) begin
				mem[{a_addr_reg[ADDR_W-1:SECT_W], idx_reg[SECT_W-1:0]}] <= `FCE_ERASED;
				if (idx_reg[SECT_W-1:0] == {SECT_W{1'b1}})
					state_reg <= ST_TAIL;
			end else begin
				mem[idx_reg] <= `FCE_ERASED;
				if (idx_reg == {ADDR_W{1'b1}})
					state_reg <= ST_TAIL;
			end
			tcnt_reg <= 20'h00000;
		end
		ST_TAIL: begin
			if (finish) begin
				state_reg      <= ST_IDLE;
				hold_reg       <= 1'b0;
				abort_pend_reg <= 1'b0;
				abort_hit_reg  <= 1'b0;
				if (op_reg == `FCE_CMD_VERIFY)
					blank_reg <= ok_reg;
				if (op_reg == `FCE_CMD_COMPRESS)
					data_buf_reg <= sig_reg;
				if (abort_hit_reg)
					access_error_flag_reg <= 1'b1;
				if (!buf_valid_reg && !launch)
					command_complete_flag_reg <= 1'b1;
			end else
				tcnt_reg <= tcnt_reg - 20'h00001;
		end
		default: state_reg <= ST_IDLE;
		endcase
	end
end

endmodule

// *** tb/fce_cpu_model.sv ***
// Purpose: bus master standing in for the processor core
// Assumes: Avalon-MM slave with waitrequest, one clock
// Notes:   bench calls wr and rd; signals move only after an edge
`timescale 1ns/1ps
module fce_cpu_model (
	input  wire        sys_clk,
	output reg  [19:0] avs_address,
	output reg         avs_read,
	output reg         avs_write,
	output reg  [3:0]  avs_byteenable,
	output reg  [31:0] avs_writedata,
	input  wire [31:0] avs_readdata,
	input  wire        avs_waitrequest
);
	initial begin
		avs_address = 20'h00000;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_byteenable = 4'hF;
		avs_writedata = 32'h00000000;
	end
	task xfer(input reg w, input reg [19:0] a, input reg [31:0] d, output reg [31:0] q);
		begin
			avs_address <= a;
			avs_writedata <= d;
			avs_read <= !w;
			avs_write <= w;
			@(posedge sys_clk);
			while (avs_waitrequest) @(posedge sys_clk);
			q = avs_readdata;
			avs_read <= 1'b0;
			avs_write <= 1'b0;
			// released data must not keep showing the last value
			avs_writedata <= ~d;
			@(posedge sys_clk);
		end
	endtask
	task wr(input reg [19:0] a, input reg [31:0] d);
		reg [31:0] q;
		begin
			xfer(1'b1, a, d, q);
		end
	endtask
	task rd(input reg [19:0] a, output reg [31:0] q);
		begin
			xfer(1'b0, a, 32'h00000000, q);
		end
	endtask
endmodule

// *** tb/fce_props.sv ***
// Purpose: bus timing checks of the flash command executor
// Assumes: one wait state per access
// Notes:   sees only the top module ports
`timescale 1ns/1ps
module fce_props (
	input wire        sys_clk,
	input wire        arst_n,
	input wire [19:0] avs_address,
	input wire        avs_read,
	input wire        avs_write,
	input wire [3:0]  avs_byteenable,
	input wire [31:0] avs_writedata,
	input wire [31:0] avs_readdata,
	input wire        avs_waitrequest
);
	wire req = avs_read | avs_write;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!arst_n);
	AST_RD_ONE_WAIT: assert property ($rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest)
		else $error("read not answered after one wait");
	AST_WR_ONE_WAIT: assert property ($rose(avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
		else $error("write not answered after one wait");
	AST_WAIT_PULSE: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low too long");
	AST_IDLE_WAIT: assert property (!req |-> avs_waitrequest)
		else $error("waitrequest low with no request");
	AST_WAIT_CAUSE: assert property ($fell(avs_waitrequest) |-> $past(req) && req)
		else $error("answer without a held request");
	AST_RDATA_HOLD: assert property (!avs_read |=> $stable(avs_readdata))
		else $error("read data changed without a read");
	AST_UNMAPPED_ZERO: assert property (avs_read && !avs_waitrequest && !avs_address[19]
		&& avs_address[7:0] > 8'h10 |-> avs_readdata == 32'h00000000)
		else $error("unmapped read not zero");
	AST_NEXT_WAITS: assert property (!avs_waitrequest ##1 avs_waitrequest ##1 req
		|-> avs_waitrequest)
		else $error("back to back request not waited");
endmodule
bind fce_flash_cmd_exec fce_props u_props (.sys_clk(sys_clk), .arst_n(arst_n),
	.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
	.avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
	.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

// *** tb/fce_flash_cmd_exec_tb.sv ***
// Purpose: self-checking bench of the flash command executor
// Assumes: small block of 64 words, divider 3
// Notes:   timing read back as status at a known edge
`timescale 1ns/1ps
`include "fce_consts.vh"
module fce_flash_cmd_exec_tb;
	localparam DEPTH = 64;
	localparam DIV = 3;
	localparam [19:0] ST = 20'h00004;
	reg         sys_clk;
	reg         arst_n;
	wire [19:0] avs_address;
	wire        avs_read;
	wire        avs_write;
	wire [3:0]  avs_byteenable;
	wire [31:0] avs_writedata;
	wire [31:0] avs_readdata;
	wire        avs_waitrequest;
	integer     fail_count, checks_done, seed, cyc, lt, i;
	reg  [31:0] q;
	reg  [15:0] dat;
	fce_flash_cmd_exec #(.ADDR_W(6), .SECT_W(3)) DUT (.sys_clk(sys_clk), .arst_n(arst_n),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
	fce_cpu_model m (.sys_clk(sys_clk), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_byteenable(avs_byteenable),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest));
	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 10000) begin
			fail_count = fail_count + 1;
			close_out;
		end
	end
	function [15:0] sig(input [15:0] s, input [15:0] w);
		sig = {s[14:0], s[15] ^ s[14] ^ s[12] ^ s[3]} ^ w;
	endfunction
	function [19:0] arr(input integer w);
		arr = {2'h2, w[15:0], 2'h0};
	endfunction
	task chk(input [31:0] g, input [31:0] e);
		begin
			checks_done = checks_done + 1;
			if (g !== e) begin
				fail_count = fail_count + 1;
				$display("unexpected at %0t: got %h want %h", $time, g, e);
			end
		end
	endtask
	task st_is(input [31:0] e);
		begin
			m.rd(ST, q);
			chk(q & 32'hF4, e);
		end
	endtask
	task seq(input integer w, input [15:0] d, input [7:0] c);
		begin
			m.wr(arr(w), {16'h0000, d});
			m.wr(20'h00000, {24'h000000, c});
		end
	endtask
	task go;
		begin
			m.wr(ST, 32'h80);
			lt = cyc;
		end
	endtask
	// first read started here shows status after edge lt+k
	task at(input integer k);
		while (cyc < lt + k - 1) @(posedge sys_clk);
	endtask
	task wait_cc;
		begin
			q = 0;
			for (i = 0; i < 400 && !q[6]; i = i + 1) m.rd(ST, q);
			chk(q & 32'h40, 32'h40);
		end
	endtask
	task close_out;
		begin
			$display("counts: %0d checks, %0d mismatches", checks_done, fail_count);
			if (fail_count == 0 && checks_done > 0)
				$display("NO MISMATCHES");
			else
				$display("MISMATCHES SEEN");
			$finish;
		end
	endtask
	initial begin
		fail_count = 0;
		checks_done = 0;
		seed = 73;
		cyc = 0;
		arst_n = 1'b0;
		repeat (16) @(posedge sys_clk);
		arst_n <= 1'b1;
		@(posedge sys_clk);
		st_is(32'hC0);
		m.rd(20'h00008, q);
		chk(q & 32'hFF, 32'hA4);
		m.rd(20'h00014, q);
		chk(q, 32'h00000000);
		m.wr(20'h00010, DIV);
		$display("test reset done");
		m.wr(20'h00008, 32'h24);
		seq(0, 16'h0000, `FCE_CMD_MERASE);
		st_is(32'hE0);
		m.wr(ST, 32'h20);
		m.wr(20'h00008, 32'hA4);
		seq(0, 16'h0000, `FCE_CMD_MERASE);
		go;
		wait_cc;
		$display("test mass erase done");
		dat = $random(seed);
		seq(5, dat, `FCE_CMD_VERIFY);
		go;
		at(3);
		st_is(32'h00);
		at(DEPTH + 11);
		st_is(32'h80);
		at(DEPTH + 12);
		st_is(32'hC4);
		$display("test verify done");
		dat = $random(seed) & 16'hFFFE;
		seq(0, dat, `FCE_CMD_PROG);
		go;
		at(4);
		st_is(32'h84);
		wait_cc;
		st_is(32'hC4);
		m.rd(arr(0), q);
		chk(q & 32'hFFFF, dat);
		seq(0, 16'h0000, `FCE_CMD_VERIFY);
		go;
		wait_cc;
		st_is(32'hC0);
		$display("test program done");
		seq(DEPTH - 1, 16'h0002, `FCE_CMD_COMPRESS);
		go;
		at(23);
		st_is(32'h00);
		at(24);
		st_is(32'hC0);
		m.rd(20'h0000C, q);
		chk(q & 32'hFFFF, sig(sig(16'hFFFF, 16'hFFFF), dat));
		seq(8, 16'h0000 | (8 + ($random(seed) & 7)), `FCE_CMD_COMPRESS);
		go;
		m.wr(arr(9), 32'h0);
		st_is(32'h10);
		wait_cc;
		m.rd(20'h0000C, q);
		m.wr(ST, 32'h10);
		$display("test compress done");
		seq(0, 16'h0000, `FCE_CMD_SERASE);
		go;
		wait_cc;
		m.rd(arr(0), q);
		chk(q & 32'hFFFF, 32'hFFFF);
		seq(0, 16'h0000, `FCE_CMD_SERASE);
		go;
		repeat (4) @(posedge sys_clk);
		seq(0, 16'h0000, `FCE_CMD_ABORT);
		go;
		at(DIV + 6);
		st_is(32'hD0);
		m.wr(ST, 32'h10);
		seq(0, 16'h0000, `FCE_CMD_ABORT);
		go;
		wait_cc;
		st_is(32'hC0);
		$display("test abort done");
		m.wr(20'h00008, 32'hA0);
		seq(0, dat, `FCE_CMD_PROG);
		st_is(32'hE0);
		m.wr(ST, 32'h20);
		$display("test protection done");
		close_out;
	end
endmodule
